/* logic/usbgc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the global control registers
`ifndef USBGC_CFG_SVH
`define USBGC_CFG_SVH
`define USBGC_ADDR_W 3
`define USBGC_OFF_MAIN 3'h0
`define USBGC_OFF_CLK 3'h1
`define USBGC_OFF_DMA 3'h2
`define USBGC_OFF_REV 3'h3
`define USBGC_OFF_NODE 3'h4
`define USBGC_MAIN_SOFT_RESET_BIT 0
`define USBGC_MAIN_VGE 2
`define USBGC_MAIN_NAT 3
`define USBGC_MAIN_IRQ_PIN_STYLE_LO 6
`define USBGC_CLK_DIV_LO 0
`define USBGC_CLK_CLOCK_OUTPUT_DISABLE 7
`define USBGC_DMA_SRC_LO 0
`define USBGC_DMA_DMA_REQUEST_TIMING 3
`define USBGC_DMA_DEN 7
`define USBGC_DIV_RESET 4'hB
`define USBGC_REV_DEFAULT 4'h5
`define USBGC_SOFT_RESET_BIT_CYCLES 4'h8
`endif

/* logic/usbgc_pkg.sv */
// Types of the global control registers
package usbgc_pkg;
	typedef enum logic [1:0] {
		USBGC_IRQ_OFF = 2'h0,
		USBGC_IRQ_OD_LOW = 2'h1,
		USBGC_IRQ_PP_HIGH = 2'h2,
		USBGC_IRQ_PP_LOW = 2'h3
	} usbgc_irq_style_t;
	typedef enum logic [1:0] {
		USBGC_NODE_RESET = 2'h0,
		USBGC_NODE_RESUME = 2'h1,
		USBGC_NODE_OPER = 2'h2,
		USBGC_NODE_SUSPEND = 2'h3
	} usbgc_node_state_t;
	typedef enum {
		USBGC_DMA_IDLE,
		USBGC_DMA_RUN,
		USBGC_DMA_DRAIN
	} usbgc_dma_state_t;
endpackage : usbgc_pkg

/* logic/usbgc_clock_out_divisor.sv */
// Glitch-free divided clock output with freeze control
`timescale 1ns/1ps
`include "usbgc_cfg.svh"
module usbgc_clock_out_divisor #(
	parameter int DIV_W = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic freeze,
	output logic clk_out
);
	logic [DIV_W-1:0] phase_cnt;
	logic [DIV_W-1:0] phase_len;
	logic phase_end;

	// Live divisor sets the current phase length, so a change stretches or cuts it in place
	always_comb begin
		if (clk_out)
			phase_len = divisor - (divisor >> 1);
		else
			phase_len = (divisor >> 1) + {{(DIV_W-1){1'b0}}, 1'b1};
		if (phase_len == '0)
			phase_len = {{(DIV_W-1){1'b0}}, 1'b1};
	end

	assign phase_end = (phase_cnt + {{(DIV_W-1){1'b0}}, 1'b1}) >= phase_len;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_cnt <= '0;
			clk_out <= 1'b0;
		end else if (freeze) begin
			phase_cnt <= phase_cnt;
		end else if (phase_end) begin
			phase_cnt <= '0;
			clk_out <= ~clk_out;
		end else begin
			phase_cnt <= phase_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	AST_CLK_FROZEN: assert property (@(posedge ref_clk) disable iff (!rst_n) freeze |=> $stable(clk_out))
		else $error("clock output moved while frozen");
	// A release from freeze may meet a stale count once; that phase ends at the next edge
	AST_CLK_PHASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!freeze && !$past(freeze) && $stable(divisor)) |-> phase_cnt <= divisor)
		else $error("phase counter ran past divisor");
endmodule : usbgc_clock_out_divisor

/* logic/usbgc_regs.sv */
// Global control register bank: reset, attach, irq style, clock out, DMA request
// Summary of operation
// - Reserved bits read zero here; firmware writes zeros into reserved positions.
// - Soft reset bit resets everything except clock config, then clears itself.
// - Regulator enable resets to zero; setting it powers the regulator.
// - Attach bit clear forces SE0 on the bus; set releases the bus.
// - Two-bit irq style: off, open-drain low, push-pull high, push-pull low.
// - Clock out frequency is base clock over divisor plus one, over two for divisor zero; divisor resets 11.
// - Divisor change alters the current phase length, avoiding glitches.
// - Clock output disable freezes the pin at its present level.
// - Three-bit DMA source selects endpoints 1 to 6; codes 11x reserved.
// - Completion timing requests on transmit done or receive last flag.
// - Warning timing requests when the selected FIFO warning flag sets.
// - Transmit completion request holds until status read or transmit-last command.
// - Transmit warning request holds until warning clears or transmit done sets.
// - Receive completion request holds until status read or FIFO empty.
// - Receive warning request holds until warning clears or FIFO flushed.
// - Requests only while selected endpoint and DMA are both enabled.
// - Clearing DMA enable stops after the running cycle, or at once; here the request drops at once in both cases.
// - In serial host mode DMA cannot be enabled; enable writes ignored.
// - Revision register shows a read-only four-bit code in low bits.
// - Node state field: reset, resume, operational, suspend; firmware writes it.
`timescale 1ns/1ps
`include "usbgc_cfg.svh"
module usbgc_regs #(
	parameter logic [3:0] REVISION = `USBGC_REV_DEFAULT, // Arbitrary value
	parameter logic [3:0] SOFT_RESET_BIT_CYCLES = `USBGC_SOFT_RESET_BIT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [`USBGC_ADDR_W-1:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	input wire logic serial_mode_pin,
	output logic soft_reset,
	output logic regulator_enable,
	output logic force_se0,
	output usbgc_pkg::usbgc_node_state_t node_state_field,
	input wire logic irq_event,
	output logic irq_pin_out,
	output logic irq_pin_oe,
	output logic divided_clock_pin,
	input wire logic [6:1] ep_enable,
	input wire logic [6:1] tx_done_flag,
	input wire logic [6:1] rx_last_flag,
	input wire logic [6:1] fifo_warn_flag,
	input wire logic [6:1] fifo_empty_flag,
	input wire logic [6:1] fifo_flushed,
	input wire logic [6:1] tx_last_cmd,
	input wire logic dma_ack_pin,
	output logic dma_req
);
	import usbgc_pkg::*;

	logic node_attach_bit;
	usbgc_irq_style_t irq_pin_style;
	logic [3:0] clock_out_divisor;
	logic clock_output_disable;
	logic dma_enable_bit;
	logic dma_request_timing;
	logic [2:0] dma_source_select;
	logic [3:0] soft_reset_bit_cnt;
	logic [2:0] strap_sync;
	logic serial_mode;
	logic [2:0] ack_sync;
	logic dma_ack;
	usbgc_dma_state_t dma_state;
	logic req_cond;
	logic [2:0] ep_idx;

	function automatic logic wr_hit(input logic [`USBGC_ADDR_W-1:0] off);
		wr_hit = host_wr && (host_addr == off);
	endfunction : wr_hit

	// Soft reset pulse; clock config stays out of it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_reset_bit_cnt <= 4'h0;
		end else if (soft_reset_bit_cnt != 4'h0) begin
			soft_reset_bit_cnt <= soft_reset_bit_cnt - 4'h1;
		end else if (wr_hit(`USBGC_OFF_MAIN) && host_wdata[`USBGC_MAIN_SOFT_RESET_BIT]) begin
			soft_reset_bit_cnt <= SOFT_RESET_BIT_CYCLES;
		end
	end
	assign soft_reset = (soft_reset_bit_cnt != 4'h0);

	// Strap caught through three flops; two agreeing stages update it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_sync <= 3'h0;
			serial_mode <= 1'b0;
		end else begin
			strap_sync <= {strap_sync[1:0], serial_mode_pin};
			if (strap_sync[1] == strap_sync[2])
				serial_mode <= strap_sync[2];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_sync <= 3'h0;
			dma_ack <= 1'b0;
		end else begin
			ack_sync <= {ack_sync[1:0], dma_ack_pin};
			if (ack_sync[1] == ack_sync[2])
				dma_ack <= ack_sync[2];
		end
	end

	// Main control
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regulator_enable <= 1'b0;
			node_attach_bit <= 1'b0;
			irq_pin_style <= USBGC_IRQ_OFF;
		end else if (soft_reset) begin
			regulator_enable <= 1'b0;
			node_attach_bit <= 1'b0;
			irq_pin_style <= USBGC_IRQ_OFF;
		end else if (wr_hit(`USBGC_OFF_MAIN)) begin
			regulator_enable <= host_wdata[`USBGC_MAIN_VGE];
			node_attach_bit <= host_wdata[`USBGC_MAIN_NAT];
			irq_pin_style <= usbgc_irq_style_t'(host_wdata[`USBGC_MAIN_IRQ_PIN_STYLE_LO +: 2]);
		end
	end
	assign force_se0 = ~node_attach_bit;

	// Interrupt pin style
	always_comb begin
		case (irq_pin_style)
			USBGC_IRQ_OD_LOW: begin
				irq_pin_out = 1'b0;
				irq_pin_oe = irq_event;
			end
			USBGC_IRQ_PP_HIGH: begin
				irq_pin_out = irq_event;
				irq_pin_oe = 1'b1;
			end
			USBGC_IRQ_PP_LOW: begin
				irq_pin_out = ~irq_event;
				irq_pin_oe = 1'b1;
			end
			default: begin
				irq_pin_out = 1'b0;
				irq_pin_oe = 1'b0;
			end
		endcase
	end

	// Clock config survives soft reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clock_out_divisor <= `USBGC_DIV_RESET;
			clock_output_disable <= 1'b0;
		end else if (wr_hit(`USBGC_OFF_CLK)) begin
			clock_out_divisor <= host_wdata[`USBGC_CLK_DIV_LO +: 4];
			clock_output_disable <= host_wdata[`USBGC_CLK_CLOCK_OUTPUT_DISABLE];
		end
	end

	usbgc_clock_out_divisor #(
		.DIV_W(4)
	) u_clock_out_divisor (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.divisor(clock_out_divisor),
		.freeze(clock_output_disable),
		.clk_out(divided_clock_pin)
	);

	// DMA control
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_enable_bit <= 1'b0;
			dma_request_timing <= 1'b0;
			dma_source_select <= 3'h0;
		end else if (soft_reset) begin
			dma_enable_bit <= 1'b0;
			dma_request_timing <= 1'b0;
			dma_source_select <= 3'h0;
		end else if (wr_hit(`USBGC_OFF_DMA)) begin
			dma_enable_bit <= host_wdata[`USBGC_DMA_DEN] & ~serial_mode;
			dma_request_timing <= host_wdata[`USBGC_DMA_DMA_REQUEST_TIMING];
			dma_source_select <= host_wdata[`USBGC_DMA_SRC_LO +: 3];
		end else if (serial_mode) begin
			dma_enable_bit <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			node_state_field <= USBGC_NODE_RESET;
		end else if (soft_reset) begin
			node_state_field <= USBGC_NODE_RESET;
		end else if (wr_hit(`USBGC_OFF_NODE)) begin
			node_state_field <= usbgc_node_state_t'(host_wdata[1:0]);
		end
	end

	// Request condition; codes are endpoint minus one, even codes are transmit
	assign ep_idx = dma_source_select + 3'h1;
	always_comb begin
		req_cond = 1'b0;
		if (dma_source_select[2:1] != 2'b11 && ep_enable[ep_idx]) begin
			if (!dma_source_select[0]) begin
				if (!dma_request_timing)
					req_cond = tx_done_flag[ep_idx] & ~tx_last_cmd[ep_idx];
				else
					req_cond = fifo_warn_flag[ep_idx] & ~tx_done_flag[ep_idx];
			end else begin
				if (!dma_request_timing)
					req_cond = rx_last_flag[ep_idx] & ~fifo_empty_flag[ep_idx];
				else
					req_cond = fifo_warn_flag[ep_idx] & ~fifo_flushed[ep_idx];
			end
		end
	end

	// A cycle in progress is one the controller has acknowledged
	// Request drops at once; drain only blocks a new request until the ack falls
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_state <= USBGC_DMA_IDLE;
		end else if (soft_reset) begin
			dma_state <= USBGC_DMA_IDLE;
		end else begin
			case (dma_state)
				USBGC_DMA_IDLE: begin
					if (dma_enable_bit)
						dma_state <= USBGC_DMA_RUN;
				end
				USBGC_DMA_RUN: begin
					if (!dma_enable_bit)
						dma_state <= dma_ack ? USBGC_DMA_DRAIN : USBGC_DMA_IDLE;
				end
				USBGC_DMA_DRAIN: begin
					if (!dma_ack)
						dma_state <= USBGC_DMA_IDLE;
				end
				default: dma_state <= USBGC_DMA_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			dma_req <= 1'b0;
		else
			dma_req <= req_cond && dma_state == USBGC_DMA_RUN && dma_enable_bit;
	end

	// Read data; reserved bits return zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_rdata <= 8'h00;
		end else if (host_rd) begin
			case (host_addr)
				`USBGC_OFF_MAIN: host_rdata <= {irq_pin_style, 2'b00, node_attach_bit, regulator_enable, 1'b0,
					soft_reset};
				`USBGC_OFF_CLK: host_rdata <= {clock_output_disable, 3'b000, clock_out_divisor};
				`USBGC_OFF_DMA: host_rdata <= {dma_enable_bit, 3'b000, dma_request_timing, dma_source_select};
				`USBGC_OFF_REV: host_rdata <= {4'h0, REVISION};
				`USBGC_OFF_NODE: host_rdata <= {6'h00, node_state_field};
				default: host_rdata <= 8'h00;
			endcase
		end
	end

	AST_SOFT_RESET_BIT_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(soft_reset) |-> soft_reset [*8] ##1 !soft_reset)
		else $error("soft reset pulse length wrong");
	AST_SOFT_RESET_BIT_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		soft_reset |=> !regulator_enable && !node_attach_bit && !dma_enable_bit)
		else $error("soft reset left control bits set");
	AST_SOFT_RESET_BIT_KEEPS_CLK: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(soft_reset && !host_wr) |=> $stable(clock_out_divisor))
		else $error("soft reset touched clock config");
	// Bus is only released by a host write of the attach bit
	AST_SE0: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(force_se0) |-> $past(host_wr && host_addr == `USBGC_OFF_MAIN
			&& host_wdata[`USBGC_MAIN_NAT]))
		else $error("se0 released without attach write");
	AST_VGE_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(host_wr && host_addr == `USBGC_OFF_MAIN && !soft_reset)
			|=> regulator_enable == $past(host_wdata[`USBGC_MAIN_VGE]))
		else $error("regulator enable not written");
	AST_IRQ_OD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(irq_pin_style == USBGC_IRQ_OD_LOW) |-> (irq_pin_oe == irq_event && !irq_pin_out))
		else $error("open drain irq misdriven");
	AST_SERIAL_NO_DMA: assert property (@(posedge ref_clk) disable iff (!rst_n)
		serial_mode ##1 serial_mode |-> !dma_enable_bit)
		else $error("dma enabled in serial mode");
	AST_REQ_GATED: assert property (@(posedge ref_clk) disable iff (!rst_n)
		dma_req |-> $past(dma_enable_bit) && $past(ep_enable[ep_idx]))
		else $error("dma request while disabled");
	AST_RSVD_SRC: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(dma_source_select[2:1] == 2'b11) |=> !dma_req)
		else $error("request from reserved source");
	AST_DEN_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		($fell(dma_enable_bit) && !dma_ack) |-> ##[1:2] !dma_req)
		else $error("dma not stopped after enable cleared");
endmodule : usbgc_regs

/* bench/usbgc_dma_peer.sv */
// Behavioural DMA controller that answers requests promptly or slowly
`timescale 1ns/1ps
module usbgc_dma_peer (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic dma_req,
	input wire logic slow,
	output logic dma_ack_pin
);
	// Ack held two cycles per transfer; slow mode waits six cycles before the ack instead of one
	always begin
		@(posedge ref_clk);
		if (!rst_n) begin
			dma_ack_pin <= 1'h0;
		end else if (dma_req) begin
			repeat (slow ? 6 : 1) @(posedge ref_clk);
			dma_ack_pin <= 1'h1;
			repeat (2) @(posedge ref_clk);
			dma_ack_pin <= 1'h0;
		end
	end
endmodule : usbgc_dma_peer

/* bench/usb_node_global_control_regs_bench.sv */
// Self-checking bench of the global control register bank
`timescale 1ns/1ps
`include "usbgc_cfg.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module usb_node_global_control_regs_bench;
	import usbgc_pkg::*;
	logic ref_clk = 0, rst_n = 0, host_wr = 0, host_rd = 0, serial_mode_pin = 0, irq_event = 0, slow = 0;
	logic [2:0] host_addr = 0;
	logic [7:0] host_wdata = 0, host_rdata;
	logic [6:1] ep_enable = 0, tx_done_flag = 0, rx_last_flag = 0, fifo_warn_flag = 0;
	logic [6:1] fifo_empty_flag = 0, fifo_flushed = 0, tx_last_cmd = 0;
	logic soft_reset, regulator_enable, force_se0, irq_pin_out, irq_pin_oe, divided_clock_pin, dma_req, dma_ack_pin, v;
	usbgc_node_state_t node_state_field;
	int n_fail = 0, check_count = 0, seed = 86270, i, j, c;
	always #5 ref_clk = ~ref_clk;
	usbgc_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr),
		.host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .serial_mode_pin(serial_mode_pin),
		.soft_reset(soft_reset), .regulator_enable(regulator_enable), .force_se0(force_se0),
		.node_state_field(node_state_field), .irq_event(irq_event), .irq_pin_out(irq_pin_out),
		.irq_pin_oe(irq_pin_oe), .divided_clock_pin(divided_clock_pin), .ep_enable(ep_enable),
		.tx_done_flag(tx_done_flag), .rx_last_flag(rx_last_flag), .fifo_warn_flag(fifo_warn_flag),
		.fifo_empty_flag(fifo_empty_flag), .fifo_flushed(fifo_flushed), .tx_last_cmd(tx_last_cmd),
		.dma_ack_pin(dma_ack_pin), .dma_req(dma_req));
	usbgc_dma_peer peer (.ref_clk(ref_clk), .rst_n(rst_n), .dma_req(dma_req), .slow(slow), .dma_ack_pin(dma_ack_pin));
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	// Callers keep reserved positions at zero
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'h1;
		@(posedge ref_clk);
		host_wr <= 1'h0;
	endtask : wr
	task rdchk(input logic [2:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		host_addr <= a;
		host_rd <= 1'h1;
		@(posedge ref_clk);
		host_rd <= 1'h0;
		@(posedge ref_clk);
		`CHK("rdata", e, host_rdata)
	endtask : rdchk
	task wait_rise(output int n);
		n = 0;
		while (divided_clock_pin !== 1'h0 && n < 40) begin @(posedge ref_clk); n++; end
		while (divided_clock_pin !== 1'h1 && n < 40) begin @(posedge ref_clk); n++; end
	endtask : wait_rise
	function logic [7:0] rst_val(input int a);
		return (a == 1) ? 8'h0B : (a == 3) ? {4'h0, `USBGC_REV_DEFAULT} : 8'h00;
	endfunction : rst_val
	function logic exp_req(input logic [2:0] s, input logic t);
		int n;
		logic a;
		n = s + 1;
		if (s > 3'h5) return 1'h0;
		if (!t) a = s[0] ? rx_last_flag[n] & ~fifo_empty_flag[n] : tx_done_flag[n] & ~tx_last_cmd[n];
		else a = s[0] ? fifo_warn_flag[n] & ~fifo_flushed[n] : fifo_warn_flag[n] & ~tx_done_flag[n];
		return a & ep_enable[n];
	endfunction : exp_req
	initial begin
		#200000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		for (i = 0; i < 8; i++) rdchk(i[2:0], rst_val(i));
		`CHK("se0", 1'h1, force_se0)
		wr(3'h3, 8'h0A);
		rdchk(3'h3, rst_val(3));
		// External supply assumed, so attach may follow at once
		wr(3'h0, 8'h0C);
		@(posedge ref_clk);
		`CHK("vge", 1'h1, regulator_enable)
		`CHK("se0", 1'h0, force_se0)
		for (i = 0; i < 4; i++) begin
			wr(3'h0, {i[1:0], 6'h0C});
			for (j = 0; j < 2; j++) begin
				irq_event <= j[0];
				@(posedge ref_clk);
				#1;
				`CHK("irq oe", (i == 0) ? 1'h0 : (i == 1) ? j[0] : 1'h1, irq_pin_oe)
				if (i != 0) `CHK("irq out", (i == 1) ? 1'h0 : (i == 2) ? j[0] : ~j[0], irq_pin_out)
			end
		end
		for (i = 0; i < 4; i++) begin
			wr(3'h4, i[7:0]);
			rdchk(3'h4, i[7:0]);
			`CHK("node", i[1:0], node_state_field)
		end
		for (i = 0; i < 6; i++) begin
			v = 1'h0;
			j = (i < 4) ? i * 5 : $random(seed) & 15;
			wr(3'h1, {4'h0, j[3:0]});
			repeat (2) wait_rise(c);
			wait_rise(c);
			`CHK("clk period", (j == 0) ? 2 : j + 1, c)
			wr(3'h1, {4'h8, j[3:0]});
			@(posedge ref_clk);
			v = divided_clock_pin;
			repeat (12) begin @(posedge ref_clk); `CHK("clk frozen", v, divided_clock_pin) end
		end
		for (i = 0; i < 16; i++) begin
			wr(3'h2, {4'h8, i[3], i[2:0]});
			for (j = 0; j < 6; j++) begin
				@(posedge ref_clk);
				ep_enable <= (j == 0) ? 6'h3F : 6'($random(seed));
				tx_done_flag <= (j == 0) ? {6{~i[3]}} : 6'($random(seed));
				rx_last_flag <= (j == 0) ? 6'h3F : 6'($random(seed));
				fifo_warn_flag <= (j == 0) ? 6'h3F : 6'($random(seed));
				fifo_empty_flag <= (j == 0) ? 6'h00 : 6'($random(seed) & $random(seed));
				fifo_flushed <= (j == 0) ? 6'h00 : 6'($random(seed) & $random(seed));
				tx_last_cmd <= (j == 0) ? 6'h00 : 6'($random(seed) & $random(seed));
				slow <= 1'($random(seed));
				repeat (4) @(posedge ref_clk);
				`CHK("dma req", exp_req(i[2:0], i[3]), dma_req)
			end
		end
		wr(3'h2, 8'h80);
		@(posedge ref_clk);
		ep_enable <= 6'h3F;
		tx_done_flag <= 6'h3F;
		tx_last_cmd <= 6'h00;
		slow <= 1'h1;
		repeat (4) @(posedge ref_clk);
		`CHK("dma req on", 1'h1, dma_req)
		wr(3'h2, 8'h00);
		c = 0;
		while (dma_req !== 1'h0 && c < 40) begin @(posedge ref_clk); c++; end
		`CHK("dma stop", 1'h0, dma_req)
		serial_mode_pin <= 1'h1;
		repeat (5) @(posedge ref_clk);
		wr(3'h2, 8'h80);
		rdchk(3'h2, 8'h00);
		`CHK("dma serial", 1'h0, dma_req)
		serial_mode_pin <= 1'h0;
		wr(3'h1, 8'h05);
		wr(3'h4, 8'h02);
		wr(3'h0, 8'h0D);
		c = 0;
		while (soft_reset !== 1'h1 && c < 4) begin @(posedge ref_clk); c++; end
		c = 0;
		while (soft_reset === 1'h1 && c < 30) begin @(posedge ref_clk); c++; end
		`CHK("soft_reset_bit len", 8, c)
		rdchk(3'h0, 8'h00);
		rdchk(3'h1, 8'h05);
		rdchk(3'h4, 8'h00);
		`CHK("se0", 1'h1, force_se0)
		rst_n <= 1'h0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		rdchk(3'h1, 8'h0B);
		report_and_stop();
	end
endmodule : usb_node_global_control_regs_bench
